/* File: logic/bank_if.sv */
// Interface: per-bank open state shared with the bank tracker
`timescale 1ns/1ps
interface bank_if #(parameter int NB = 8);
    logic          act;      // Activate strobe
    logic          pre;      // Precharge strobe
    logic          pre_all;  // Precharge all strobe
    logic [2:0]    ba;       // Bank address
    logic [NB-1:0] open_map; // Open banks
    modport ctl  (output act, output pre, output pre_all, output ba, input open_map);
    modport bank (input act, input pre, input pre_all, input ba, output open_map);
endinterface : bank_if

/* File: logic/bank_state.sv */
// Bank tracker: remembers which banks hold an open row
`timescale 1ns/1ps
module bank_state #(
    parameter int NB = 8
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic clr,     // Internal reset from reset pin
    bank_if.bank      bif
);
    // ----------------------------------------------------------------
    // Per-bank open flag
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bank
            // Activate opens, precharge of this bank or precharge all closes
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    bif.open_map[g] <= 1'b0;
                end else if (clr) begin
                    bif.open_map[g] <= 1'b0;
                end else if (bif.act && bif.ba == 3'(g)) begin
                    bif.open_map[g] <= 1'b1;
                end else if (bif.pre_all || (bif.pre && bif.ba == 3'(g))) begin
                    bif.open_map[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // bank_state

/* File: logic/ddr3_pd_reset.sv */
// Device-side power-down and reset behaviour of a DDR3 memory
`timescale 1ns/1ps
module ddr3_pd_reset #(
    parameter int NB       = 8,  // Number of banks
    parameter int ROW_BUSY = 4,  // Clocks an activate or precharge stays in progress
    parameter int REF_BUSY = 16  // Clocks a refresh stays in progress
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        reset_n,     // Memory reset pin, active low
    input  wire logic        cke,         // Clock enable pin
    input  wire logic [3:0]  cmd,         // cs_n, ras_n, cas_n, we_n
    input  wire logic [2:0]  ba,          // Bank address
    input  wire logic [15:0] addr,        // Address bus
    input  wire logic        odt,         // Termination control pin
    output logic             pd_active,   // Active power-down
    output logic             pd_precharge,// Precharge power-down
    output logic             dll_on,      // DLL running
    output logic             buf_en,      // Input/output buffers enabled
    output logic             odt_async,   // Termination in asynchronous mode
    output logic             rtt_on,      // Termination applied
    output logic             out_en,      // Data outputs may drive
    output logic             in_reset,    // Device held in reset
    output logic [2:0]       wr_code,     // Programmed write recovery
    output logic [15:0]      ref_count    // Internal refresh counter
);
    // ----------------------------------------------------------------
    // State and bank tracking
    // ----------------------------------------------------------------
    localparam int BUSY_W = pd_pkg::BUSY_W; // Counter width, declared before its first use
    pd_pkg::pwr_t        state;        // Power state
    logic                fast_exit;    // Stored exit mode bit
    logic [BUSY_W-1:0]   busy;         // In-progress internal operation
    logic [4:0]          dll_cnt;      // Asynchronous termination hold
    logic                cke_q;        // Previous clock enable
    logic                nop;          // Command is NOP or deselect
    logic                any_open;     // Any bank open

    bank_if #(.NB(NB)) bif ();

    assign nop      = cmd[3] || (cmd == pd_pkg::CMD_NOP);
    assign any_open = |bif.open_map;
    assign bif.act     = (state == pd_pkg::ST_UP) && cke && cmd == pd_pkg::CMD_ACT;
    assign bif.pre     = (state == pd_pkg::ST_UP) && cke && cmd == pd_pkg::CMD_PRE;
    assign bif.pre_all = bif.pre && addr[pd_pkg::A_AP];
    assign bif.ba      = ba;

    // Bank tracker, cleared while reset pin low
    bank_state #(.NB(NB)) u_bank (
        .mclk (mclk),
        .rst  (rst),
        .clr  (!reset_n),
        .bif  (bif)
    );

    // ----------------------------------------------------------------
    // Mode register capture
    // ----------------------------------------------------------------
    // MRS loads exit mode and write recovery; bank address picks register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fast_exit <= pd_pkg::FAST_RST;
            wr_code   <= pd_pkg::WR_RST;
        end else if (!reset_n) begin
            fast_exit <= pd_pkg::FAST_RST;
            wr_code   <= pd_pkg::WR_RST;
        end else if (state == pd_pkg::ST_UP && cke && cmd == pd_pkg::CMD_MRS) begin
            if (ba == 3'h0) begin
                wr_code <= addr[pd_pkg::MR0_WR_HI:pd_pkg::MR0_WR_LO];
            end
            if (ba == 3'h1) begin
                fast_exit <= addr[pd_pkg::MR1_FAST];
            end
        end
    end

    // ----------------------------------------------------------------
    // In-progress row, precharge and refresh work
    // ----------------------------------------------------------------
    // finish internal work first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy <= '0;
        end else if (!reset_n) begin
            busy <= '0;
        end else if (state == pd_pkg::ST_UP && cke && cmd == pd_pkg::CMD_REF) begin
            busy <= BUSY_W'(REF_BUSY);
        end else if (bif.act || bif.pre) begin
            busy <= BUSY_W'(ROW_BUSY);
        end else if (busy != '0) begin
            busy <= busy - BUSY_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Refresh counter
    // ----------------------------------------------------------------
    // reset clears refresh counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_count <= '0;
        end else if (!reset_n) begin
            ref_count <= '0;
        end else if (state == pd_pkg::ST_UP && cke && cmd == pd_pkg::CMD_REF) begin
            ref_count <= ref_count + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    // Reset pin wins in every state; it is sampled on mclk edges, so a low pulse between edges is missed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= pd_pkg::ST_RESET;
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke;
            if (!reset_n) begin
                state <= pd_pkg::ST_RESET;
            end else begin
                case (state)
                    pd_pkg::ST_RESET: begin
                        // Leave reset once the pin is high and CKE is sampled high on the same edge (cke, not cke_q)
                        if (cke) begin
                            state <= pd_pkg::ST_UP;
                        end
                    end
                    pd_pkg::ST_UP: begin
                        // entry on CKE low with NOP
                        if (!cke && nop) begin
                            state <= pd_pkg::ST_SETTL;
                        end
                    end
                    pd_pkg::ST_SETTL: begin
                        if (cke && nop) begin
                            state <= pd_pkg::ST_EXIT;
                        end else if (busy == '0) begin
                            state <= pd_pkg::ST_DOWN;
                        end
                    end
                    pd_pkg::ST_DOWN: begin
                        // exit on CKE high with NOP
                        if (cke && nop) begin
                            state <= pd_pkg::ST_EXIT;
                        end
                    end
                    pd_pkg::ST_EXIT: begin
                        state <= pd_pkg::ST_UP;
                    end
                    default: begin
                        state <= pd_pkg::ST_RESET;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Power-down mode flags
    // ----------------------------------------------------------------
    // Mode is settled only once internal work is over
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pd_active    <= 1'b0;
            pd_precharge <= 1'b0;
            dll_on       <= 1'b0;
        end else if (!reset_n) begin
            pd_active    <= 1'b0;
            pd_precharge <= 1'b0;
            dll_on       <= 1'b0;
        end else if (state == pd_pkg::ST_SETTL && busy == '0 && !cke) begin
            pd_active    <= any_open;
            pd_precharge <= !any_open;
            // exit bit keeps or stops DLL
            dll_on       <= any_open || fast_exit;
        end else if (state == pd_pkg::ST_DOWN) begin
            dll_on <= dll_on;
        end else begin
            pd_active    <= 1'b0;
            pd_precharge <= 1'b0;
            dll_on       <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Buffer gating
    // ----------------------------------------------------------------
    // buffers off while down; CKE, clock, ODT and reset stay live
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_en <= 1'b0;
        end else begin
            buf_en <= reset_n && (state == pd_pkg::ST_UP || state == pd_pkg::ST_EXIT);
        end
    end

    // ----------------------------------------------------------------
    // Asynchronous termination window
    // ----------------------------------------------------------------
    // slow exit holds async mode for DLL relock after CKE rises
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            odt_async <= 1'b0;
            dll_cnt   <= '0;
        end else if (!reset_n) begin
            odt_async <= 1'b0;
            dll_cnt   <= '0;
        end else if (state == pd_pkg::ST_UP && !cke && nop && !any_open && !fast_exit) begin
            odt_async <= 1'b1;
            dll_cnt   <= 5'(pd_pkg::XPDLL_CYC);
        end else if (odt_async && cke && cke_q) begin
            // Count only after exit is registered
            if (dll_cnt == 5'h01) begin
                odt_async <= 1'b0;
            end
            dll_cnt <= dll_cnt - 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Reset-driven outputs and termination
    // ----------------------------------------------------------------
    // outputs and termination off while reset low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_reset <= 1'b1;
            out_en   <= 1'b0;
            rtt_on   <= 1'b0;
        end else begin
            in_reset <= !reset_n || state == pd_pkg::ST_RESET;
            out_en   <= reset_n && state == pd_pkg::ST_UP;
            rtt_on   <= reset_n && state != pd_pkg::ST_RESET && odt;
        end
    end
endmodule // ddr3_pd_reset

/* File: logic/pd_pkg.sv */
// Package: constants and types for the DDR3 power-down and reset tracker
package pd_pkg;
    // ----------------------------------------------------------------
    // Command encoding (cs_n, ras_n, cas_n, we_n)
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_NOP   = 4'h7; // 0111
    localparam logic [3:0] CMD_ACT   = 4'h3; // 0011
    localparam logic [3:0] CMD_RD    = 4'h5; // 0101
    localparam logic [3:0] CMD_WR    = 4'h4; // 0100
    localparam logic [3:0] CMD_PRE   = 4'h2; // 0010
    localparam logic [3:0] CMD_REF   = 4'h1; // 0001
    localparam logic [3:0] CMD_MRS   = 4'h0; // 0000
    localparam logic [3:0] CMD_ZQ    = 4'h6; // 0110
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int A_AP      = 10;     // Auto precharge address bit
    localparam int MR1_FAST  = 12;     // Precharge power-down exit mode
    localparam int MR0_WR_HI = 11;     // Write recovery field
    localparam int MR0_WR_LO = 9;
    localparam logic [2:0] WR_RST = 3'h1; // Write recovery code after reset
    localparam logic       FAST_RST = 1'b0; // Slow exit after reset
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PS       = 50000;  // 20 MHz period in ps
    localparam int RST_MIN_NS   = 100;    // Least reset low time
    localparam int RST_MIN_CYC  = (RST_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int XPDLL_CK     = 10;     // DLL exit minimum clocks
    localparam int XPDLL_NS     = 24;     // DLL exit minimum time
    localparam int XPDLL_NS_CYC = (XPDLL_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int XPDLL_CYC    = (XPDLL_CK > XPDLL_NS_CYC) ? XPDLL_CK : XPDLL_NS_CYC;
    localparam int CPDED_CYC    = 1;      // Buffer disable delay after entry
    localparam int BUSY_W       = 6;      // Width of in-progress counters
    // ----------------------------------------------------------------
    // Power state, Gray coded along idle -> entering -> down -> exiting
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'h4,
        ST_UP    = 3'h0,
        ST_SETTL = 3'h1,
        ST_DOWN  = 3'h3,
        ST_EXIT  = 3'h2
    } pwr_t;
endpackage : pd_pkg

/* File: sim/ddr3_pd_reset_monitor.sv */
// Port-level assertions for the power-down and reset block
`timescale 1ns/1ps
module ddr3_pd_reset_monitor #(
    parameter int NB       = 8,
    parameter int ROW_BUSY = 4,
    parameter int REF_BUSY = 16
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        reset_n,
    input wire logic        cke,
    input wire logic [3:0]  cmd,
    input wire logic [2:0]  ba,
    input wire logic [15:0] addr,
    input wire logic        odt,
    input wire logic        pd_active,
    input wire logic        pd_precharge,
    input wire logic        dll_on,
    input wire logic        buf_en,
    input wire logic        odt_async,
    input wire logic        rtt_on,
    input wire logic        out_en,
    input wire logic        in_reset,
    input wire logic [2:0]  wr_code,
    input wire logic [15:0] ref_count
);
    // Longest wait for entry: a refresh still running plus margin
    localparam int LIM = REF_BUSY + 4;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Low clock enable with NOP while the buffers are live
    sequence entry_req;
        buf_en && !cke && cmd == pd_pkg::CMD_NOP && reset_n;
    endsequence
    // High clock enable with NOP while powered down
    sequence exit_req;
        (pd_active || pd_precharge) && cke && cmd == pd_pkg::CMD_NOP && reset_n;
    endsequence
    // Termination stays asynchronous through the DLL exit delay, then leaves
    sequence async_hold;
        odt_async [*8] ##[2:6] !odt_async;
    endsequence
    a_entry_done: assert property (entry_req ##1 (!cke && reset_n) [*8] |->
        ##[0:LIM] (pd_active || pd_precharge)) else $error("power-down not reached");
    a_exit_up: assert property (exit_req ##1 reset_n |->
        ##2 (!pd_active && !pd_precharge && buf_en)) else $error("power-down not left");
    a_async_hold: assert property ($rose(cke) && odt_async && reset_n |-> async_hold)
        else $error("asynchronous termination window wrong");
    a_down_quiet: assert property ((pd_active || pd_precharge) |-> !buf_en && !out_en)
        else $error("buffers live in power-down");
    a_active_dll: assert property (pd_active |-> dll_on && !pd_precharge)
        else $error("active power-down lost the DLL");
    a_slow_async: assert property (pd_precharge |-> dll_on == !odt_async)
        else $error("exit mode and termination mode disagree");
    a_reset_clear: assert property (!reset_n |=> in_reset && !pd_active && !pd_precharge
        && ref_count == 16'h0000 && wr_code == pd_pkg::WR_RST) else $error("reset not taken");
    a_reset_quiet: assert property (in_reset |-> !out_en && !rtt_on && !buf_en)
        else $error("outputs live in reset");
    a_wr_capture: assert property (buf_en && cke && reset_n && cmd == pd_pkg::CMD_MRS
        && ba == 3'h0 |=> wr_code == $past(addr[11:9])) else $error("write recovery lost");
endmodule // ddr3_pd_reset_monitor
bind ddr3_pd_reset ddr3_pd_reset_monitor #(.NB(NB), .ROW_BUSY(ROW_BUSY), .REF_BUSY(REF_BUSY))
    mon (.mclk(mclk), .rst(rst), .reset_n(reset_n), .cke(cke), .cmd(cmd), .ba(ba),
    .addr(addr), .odt(odt), .pd_active(pd_active), .pd_precharge(pd_precharge),
    .dll_on(dll_on), .buf_en(buf_en), .odt_async(odt_async), .rtt_on(rtt_on),
    .out_en(out_en), .in_reset(in_reset), .wr_code(wr_code), .ref_count(ref_count));

/* File: sim/ddr3_pd_reset_tb.sv */
// Self-checking bench for the power-down and reset block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module ddr3_pd_reset_tb;
    logic        mclk = 1'b0;  // 20 MHz clock
    logic        rst  = 1'b1;  // Block reset
    logic        reset_n, cke, odt, pd_active, pd_precharge, dll_on;
    logic        buf_en, odt_async, rtt_on, out_en, in_reset;
    logic [3:0]  cmd;
    logic [2:0]  ba, wr_code;
    logic [15:0] addr, ref_count;
    int          fail_count = 0;
    int          n_tests    = 0;
    always #25 mclk = ~mclk;
    pd_ctrl_model ctrl (.mclk(mclk), .reset_n(reset_n), .cke(cke), .cmd(cmd), .ba(ba),
        .addr(addr), .odt(odt));
    // Row busy stretched so entry after activate is visibly delayed
    ddr3_pd_reset #(.ROW_BUSY(8), .REF_BUSY(16)) DUT (.mclk(mclk), .rst(rst),
        .reset_n(reset_n), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr), .odt(odt),
        .pd_active(pd_active), .pd_precharge(pd_precharge), .dll_on(dll_on),
        .buf_en(buf_en), .odt_async(odt_async), .rtt_on(rtt_on), .out_en(out_en),
        .in_reset(in_reset), .wr_code(wr_code), .ref_count(ref_count));
    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Sample just after the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Enter, check mode, stay, exit, check timing of the way out
    // caller knows open banks and busy timers
    task automatic pd_cycle(input logic early, input logic act, input logic dll, input logic asy);
        int n;
        n = 0;
        ctrl.pd_in(pd_pkg::CMD_NOP);
        cyc(3);
        `CHK(pd_active | pd_precharge, early)
        while (!(pd_active | pd_precharge) && n < 30) begin
            cyc(1);
            n++;
        end
        `CHK({pd_active, pd_precharge, dll_on, buf_en, odt_async}, {act, ~act, dll, 1'b0, asy})
        cyc(10);
        ctrl.pd_out();
        cyc(4);
        `CHK({pd_active, pd_precharge, buf_en, dll_on, odt_async}, {4'b0011, asy})
        ctrl.settle();
        cyc(1);
        `CHK(odt_async, 1'b0)
    endtask
    task automatic t_power_up();
        `CHK({in_reset, out_en, rtt_on, wr_code, ref_count}, {3'b100, pd_pkg::WR_RST, 16'h0})
        ctrl.rst_hi();
        cyc(3);
        `CHK({in_reset, buf_en, out_en}, 3'b011)
    endtask
    // Slow exit: DLL off, termination asynchronous
    task automatic t_slow_exit();
        ctrl.send(pd_pkg::CMD_MRS, 3'h0, 16'h0a00);
        ctrl.send(pd_pkg::CMD_MRS, 3'h1, 16'h0000);
        cyc(1);
        `CHK(wr_code, 3'h5)
        pd_cycle(1'b1, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_fast_exit();
        ctrl.send(pd_pkg::CMD_MRS, 3'h1, 16'h1000);
        pd_cycle(1'b1, 1'b0, 1'b1, 1'b0);
    endtask
    // Open bank with slow exit chosen: DLL must still stay on
    task automatic t_active();
        ctrl.send(pd_pkg::CMD_MRS, 3'h1, 16'h0000);
        ctrl.send(pd_pkg::CMD_ACT, 3'h3, 16'h0000);
        pd_cycle(1'b0, 1'b1, 1'b1, 1'b0);
        ctrl.send(pd_pkg::CMD_PRE, 3'h0, 16'h0400);
    endtask
    // Refresh between two power-downs delays the second entry
    task automatic t_refresh();
        ctrl.send(pd_pkg::CMD_REF, 3'h0, 16'h0000);
        cyc(0);
        `CHK(ref_count, 16'h0001)
        pd_cycle(1'b0, 1'b0, 1'b0, 1'b1);
    endtask
    // Reset pin dropped while powered down
    task automatic t_pin_reset();
        ctrl.send(pd_pkg::CMD_MRS, 3'h0, 16'h0c00);
        // Deselect instead of NOP must also enter
        ctrl.pd_in(4'hf);
        cyc(6);
        `CHK(pd_precharge, 1'b1)
        ctrl.rst_lo();
        cyc(2);
        `CHK({in_reset, pd_active, pd_precharge, out_en, rtt_on}, 5'b10000)
        `CHK({wr_code, ref_count}, {pd_pkg::WR_RST, 16'h0000})
        ctrl.rst_hi();
        cyc(3);
        `CHK({in_reset, buf_en}, 2'b01)
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        cyc(2);
        t_power_up();
        t_slow_exit();
        t_fast_exit();
        t_active();
        t_refresh();
        t_pin_reset();
        stop_test();
    end
    // Whole run needs a few hundred clocks
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        stop_test();
    end
endmodule // ddr3_pd_reset_tb

/* File: sim/pd_ctrl_model.sv */
// Memory controller model driving clock enable, reset pin and commands
`timescale 1ns/1ps
module pd_ctrl_model (
    input  wire logic  mclk,
    output logic       reset_n,
    output logic       cke,
    output logic [3:0] cmd,
    output logic [2:0] ba,
    output logic [15:0] addr,
    output logic       odt
);
    // start in reset with clock enable low
    initial {reset_n, cke, odt, cmd, ba, addr} = {3'b000, pd_pkg::CMD_NOP, 19'h00000};
    // one command, then NOP; reads and writes never issued
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
        @(posedge mclk);
        {cmd, ba, addr} <= {c, b, a};
        @(posedge mclk);
        cmd <= pd_pkg::CMD_NOP;
    endtask
    // clock enable held low until the caller exits
    // idle command given with the falling enable
    task automatic pd_in(input logic [3:0] c);
        @(posedge mclk);
        {cke, cmd} <= {1'b0, c};
    endtask
    // exit with NOP, enable kept high afterwards
    task automatic pd_out();
        @(posedge mclk);
        cke <= 1'b1;
    endtask
    // wait the DLL exit delay; no read leans on the DLL
    task automatic settle();
        repeat (pd_pkg::XPDLL_CYC) @(posedge mclk);
    endtask
    // reset pin low, termination request left high on purpose
    task automatic rst_lo();
        @(posedge mclk);
        {reset_n, odt} <= 2'b01;
    endtask
    // hold the minimum, enable low before release
    task automatic rst_hi();
        @(posedge mclk);
        cke <= 1'b0;
        repeat (pd_pkg::RST_MIN_CYC) @(posedge mclk);
        {reset_n, odt} <= 2'b10;
        @(posedge mclk);
        cke <= 1'b1;
    endtask
endmodule // pd_ctrl_model
